// *** rtl/ifpc_top.sv ***
// Input pulse stretching, flutter monitoring, diagnostics and identification record
//
// Behaviour
// - No LED or entry without group diagnostics
// - Value status shows error regardless
// - Flutter monitoring only when option enabled
// - Independent window timer and counter per channel
// - Window starts at first change when idle
// - Changes above limit declare flutter error
// - Clean window expiry returns to idle
// - Error keeps image live, status invalid
// - Error records diagnostic, raises incoming interrupt
// - Clear after three quiet window lengths
// - Clear removes entry, raises outgoing interrupt
// - Clear returns value status to valid
// - Interrupt only with group diagnostics enabled
// - Pulses held active for stretch length
// - Longer pulses pass through unchanged
// - Flutter watches the stretched signal
// - Installation date field sixteen characters, writable
// - Tag and description thirty-two characters each
// - Firmware bump also bumps hardware revision
// - Group channels share one sensor type
// - Changeover pair: even open, odd closed
// - Stretch none, half, one or two seconds
// - Window half second or 1..100 seconds
// - Sensor setting applies to whole group
//
// The implementer's own choices: register access over Avalon-MM and the register addresses.
`timescale 1ns/10ps
`default_nettype none

module ifpc_chan (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic tick_in,
   input wire logic din_in,
   input wire ifpc_pkg::ifpc_cfg_type cfg_in,
   output logic cond_out,
   output logic err_out,
   output logic set_out,
   output logic clr_out
);
   import ifpc_pkg::*;

   typedef enum logic [1:0] {ST_IDLE, ST_WIN, ST_ERR} ifpc_state_type;

   ifpc_state_type state; // Monitor state
   logic din_d; // Previous raw level
   logic [10:0] hold; // Stretch time left in ms
   logic cond_d; // Previous stretched level
   logic [16:0] tmr; // Elapsed window ms
   logic [5:0] cnt; // Changes in this window
   logic [1:0] quiet; // Clean windows while in error
   logic [10:0] str_ms; // Selected stretch length
   logic [16:0] win_ms; // Selected window length
   logic rise; // Raw rising edge
   logic cond; // Stretched level
   logic chg; // Change of stretched level
   logic win_end; // Window length reached
   logic over; // Count above limit after this change

   assign str_ms = (cfg_in.stretch == STR_500) ? STR_500_MS :
                   (cfg_in.stretch == STR_1000) ? STR_1000_MS :
                   (cfg_in.stretch == STR_2000) ? STR_2000_MS : 11'h000;
   assign win_ms = (cfg_in.win == WIN_HALF) ? WIN_HALF_MS :
                   17'(cfg_in.win) * 17'(MS_PER_S);
   assign rise = din_in & ~din_d;
   // Raw level or the remaining hold; a long pulse outlives the hold untouched
   assign cond = din_in | (hold != 11'h000);
   assign chg = cond != cond_d;
   assign win_end = tick_in & (tmr + 17'h00001 >= win_ms);
   assign over = chg & ((cnt + 6'h01) > {1'b0, cfg_in.limit});

   // Stretch hold counter, loaded at each rising edge
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         din_d <= 1'b0;
         hold <= 11'h000;
      end else begin
         din_d <= din_in;
         if (rise) begin
            hold <= str_ms;
         end else if (tick_in && hold != 11'h000) begin
            hold <= hold - 11'h001;
         end
      end
   end

   // Output and edge history of the stretched level
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         cond_d <= 1'b0;
         cond_out <= 1'b0;
      end else begin
         cond_d <= cond;
         cond_out <= cond;
      end
   end

   // Flutter monitor; own timer and counter per instance
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         state <= ST_IDLE;
         tmr <= 17'h00000;
         cnt <= 6'h00;
         quiet <= 2'h0;
         set_out <= 1'b0;
         clr_out <= 1'b0;
      end else begin
         set_out <= 1'b0;
         clr_out <= 1'b0;
         unique case (state)
            ST_IDLE: begin
               if (cfg_in.flut_en && chg) begin
                  state <= ST_WIN;
                  tmr <= 17'h00000;
                  cnt <= 6'h01;
               end
            end
            ST_WIN: begin
               if (!cfg_in.flut_en) begin
                  state <= ST_IDLE;
               end else if (over) begin
                  state <= ST_ERR;
                  set_out <= 1'b1;
                  tmr <= 17'h00000;
                  cnt <= 6'h00;
                  quiet <= 2'h0;
               end else begin
                  if (chg) begin
                     cnt <= cnt + 6'h01;
                  end
                  if (win_end) begin
                     state <= ST_IDLE;
                  end else if (tick_in) begin
                     tmr <= tmr + 17'h00001;
                  end
               end
            end
            ST_ERR: begin
               // Error is cleared by quiet windows, or dropped if monitoring is turned off
               if (!cfg_in.flut_en) begin
                  state <= ST_IDLE;
                  clr_out <= 1'b1;
               end else if (over) begin
                  tmr <= 17'h00000; // Renewed flutter restarts the quiet period
                  cnt <= 6'h00;
                  quiet <= 2'h0;
               end else begin
                  if (chg) begin
                     cnt <= cnt + 6'h01;
                  end
                  if (win_end) begin
                     tmr <= 17'h00000;
                     cnt <= 6'h00;
                     if (quiet + 2'h1 == QUIET_WINDOWS) begin
                        state <= ST_IDLE;
                        clr_out <= 1'b1;
                     end else begin
                        quiet <= quiet + 2'h1;
                     end
                  end else if (tick_in) begin
                     tmr <= tmr + 17'h00001;
                  end
               end
            end
         endcase
      end
   end

   assign err_out = state == ST_ERR;
endmodule

module ifpc_top #(
   parameter int TICK_DIV = ifpc_pkg::TICK_CYCLES // Cycles per millisecond tick
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [15:0] sensor_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   output logic [31:0] avs_readdata_out,
   output logic avs_waitrequest_out,
   output logic [15:0] image_out,
   output logic [15:0] valid_out,
   output logic [15:0] led_out,
   output logic diag_in_irq_out,
   output logic diag_out_irq_out
);
   import ifpc_pkg::*;

   localparam int MAKER_CODE = 32'h00a5a501; // Arbitrary value
   localparam int DEVICE_CODE = 32'h00001610; // Arbitrary value
   localparam int SERIAL_CODE = 32'h00000001; // Arbitrary value

   logic [15:0] sync1; // First synchroniser stage
   logic [15:0] sync2; // Second synchroniser stage
   logic [16:0] div; // Tick divider
   logic tick; // One-cycle millisecond tick
   logic irq_en; // Module-wide interrupt enable
   logic [15:0] grp_en; // Group diagnostics per channel
   logic [15:0] flut_en; // Flutter option per channel
   logic [31:0] stretch; // Two bits per channel
   logic [31:0] sensor; // Four bits per group
   logic [11:0] chcfg [NUM_CH]; // Window code and limit per channel
   logic [31:0] id_mem [ID_WORDS]; // Date, tag and free text
   logic [15:0] stat_rev; // Static revision count
   logic [15:0] hw_rev; // Hardware revision
   logic [15:0] fw_rev; // Firmware revision
   logic ack; // Second cycle of an access
   logic [15:0] mapped; // Sensor-type adjusted inputs
   logic [15:0] cond; // Stretched inputs
   logic [15:0] err; // Flutter error per channel
   logic [15:0] set_p; // Error raised
   logic [15:0] clr_p; // Error cleared
   logic req; // Access pending
   logic wr_go; // Write takes effect
   logic [31:0] wmask; // Byte-lane mask
   logic cfg_hit; // Channel configuration page
   logic [3:0] ch_sel; // Addressed channel
   logic id_hit; // Identification text area
   logic [4:0] id_sel; // Addressed text word
   logic [31:0] cur; // Current value of addressed word
   logic [31:0] merged; // Byte-merged write value
   logic [6:0] win_w; // Clamped window code
   logic [4:0] lim_w; // Clamped change limit
   logic [31:0] sens_w; // Sensor write with illegal codes dropped
   logic cfg_wr; // Write to any configuration register

   // Pins cross into the clock domain through two stages
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         sync1 <= 16'h0000;
         sync2 <= 16'h0000;
      end else begin
         sync1 <= sensor_in;
         sync2 <= sync1;
      end
   end

   // Shared millisecond time base
   always_ff @(posedge clock_in) begin
      if (!rstn_in || tick) begin
         div <= 17'h00000;
      end else begin
         div <= div + 17'h00001;
      end
   end
   assign tick = div == 17'(TICK_DIV - 1);

   // Per channel sensor mapping and conditioning
   for (genvar c = 0; c < NUM_CH; c++) begin : g_ch
      logic [3:0] kind;
      ifpc_cfg_type cfg;
      // One type per group; odd of a changeover pair is the closed contact, read inverted
      assign kind = sensor[4*(c/2) +: 4];
      assign mapped[c] = (kind == SNS_OFF) ? 1'b0 :
                         ((kind >= CO_FIRST) && (c % 2 == 1)) ? ~sync2[c] : sync2[c];
      assign cfg = '{flut_en[c], stretch[2*c +: 2], chcfg[c][11:5], chcfg[c][4:0]};
      ifpc_chan u_chan (
         .clock_in(clock_in),
         .rstn_in(rstn_in),
         .tick_in(tick),
         .din_in(mapped[c]),
         .cfg_in(cfg),
         .cond_out(cond[c]),
         .err_out(err[c]),
         .set_out(set_p[c]),
         .clr_out(clr_p[c])
      );
   end

   // Process image, status, LED and interrupts
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         image_out <= 16'h0000;
         valid_out <= 16'hffff;
         led_out <= 16'h0000;
         diag_in_irq_out <= 1'b0;
         diag_out_irq_out <= 1'b0;
      end else begin
         image_out <= cond;
         valid_out <= ~err;
         led_out <= err & grp_en;
         diag_in_irq_out <= irq_en & |(set_p & grp_en);
         diag_out_irq_out <= irq_en & |(clr_p & grp_en);
      end
   end

   // Avalon decode: every access waits one cycle, then completes
   assign req = avs_read_in | avs_write_in;
   assign avs_waitrequest_out = req & ~ack;
   assign wr_go = avs_write_in & ack;
   assign wmask = {{8{avs_byteenable_in[3]}}, {8{avs_byteenable_in[2]}},
                   {8{avs_byteenable_in[1]}}, {8{avs_byteenable_in[0]}}};
   assign cfg_hit = avs_address_in[9:6] == CHCFG_PAGE;
   assign ch_sel = avs_address_in[5:2];
   assign id_hit = (avs_address_in >= ID_BASE) && (avs_address_in < ID_END);
   assign id_sel = 5'((avs_address_in - ID_BASE) >> 2);
   assign cfg_wr = wr_go && (cfg_hit || avs_address_in == REG_CTRL ||
                   avs_address_in == REG_GRP_DIAG || avs_address_in == REG_FLUT_EN ||
                   avs_address_in == REG_STRETCH || avs_address_in == REG_SENSOR);
   assign cur = (avs_address_in == REG_CTRL) ? {31'h00000000, irq_en} :
                (avs_address_in == REG_GRP_DIAG) ? {16'h0000, grp_en} :
                (avs_address_in == REG_FLUT_EN) ? {16'h0000, flut_en} :
                (avs_address_in == REG_STRETCH) ? stretch :
                (avs_address_in == REG_SENSOR) ? sensor :
                (avs_address_in == REG_IMAGE) ? {16'h0000, image_out} :
                (avs_address_in == REG_STATUS) ? {16'h0000, valid_out} :
                (avs_address_in == REG_DIAG) ? {16'h0000, led_out} :
                (avs_address_in == REG_STAT_REV) ? {16'h0000, stat_rev} :
                (avs_address_in == REG_HW_REV) ? {16'h0000, hw_rev} :
                (avs_address_in == REG_FW_REV) ? {16'h0000, fw_rev} :
                (avs_address_in == REG_MAKER) ? MAKER_CODE :
                (avs_address_in == REG_DEV_ID) ? DEVICE_CODE :
                (avs_address_in == REG_SERIAL) ? SERIAL_CODE :
                cfg_hit ? {17'h00000, chcfg[ch_sel][11:5], 3'h0, chcfg[ch_sel][4:0]} :
                id_hit ? id_mem[id_sel] : 32'h00000000;
   assign merged = (cur & ~wmask) | (avs_writedata_in & wmask);
   assign win_w = (merged[14:8] > WIN_MAX) ? WIN_MAX : merged[14:8];
   assign lim_w = (merged[4:0] < LIM_MIN) ? LIM_MIN : merged[4:0];
   // A group is written as a whole, so both its channels always agree
   for (genvar g = 0; g < NUM_GRP; g++) begin : g_sens
      assign sens_w[4*g +: 4] = (merged[4*g +: 4] > SNS_LAST) ?
                                sensor[4*g +: 4] : merged[4*g +: 4];
   end

   // Handshake and read data register
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         ack <= 1'b0;
         avs_readdata_out <= 32'h00000000;
      end else begin
         ack <= req & ~ack;
         if (avs_read_in && !ack) begin
            avs_readdata_out <= cur;
         end
      end
   end

   // Module and per-channel configuration registers
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         irq_en <= 1'b0;
         grp_en <= GRP_DIAG_RST;
         flut_en <= 16'h0000;
         stretch <= {NUM_CH{STR_NONE}};
         sensor <= {NUM_GRP{SENSOR_RST}};
      end else if (wr_go) begin
         if (avs_address_in == REG_CTRL) irq_en <= merged[0];
         if (avs_address_in == REG_GRP_DIAG) grp_en <= merged[15:0];
         if (avs_address_in == REG_FLUT_EN) flut_en <= merged[15:0];
         if (avs_address_in == REG_STRETCH) stretch <= merged;
         if (avs_address_in == REG_SENSOR) sensor <= sens_w;
      end
   end

   // Window and limit words; unaffected by read traffic
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < NUM_CH; i++) chcfg[i] <= {WIN_DEF, LIM_DEF};
      end else if (wr_go && cfg_hit) begin
         chcfg[ch_sel] <= {win_w, lim_w};
      end
   end

   // Identification text, cleared to zero at reset
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         for (int i = 0; i < ID_WORDS; i++) id_mem[i] <= 32'h00000000;
      end else if (wr_go && id_hit) begin
         id_mem[id_sel] <= merged;
      end
   end

   // Revision counters; firmware bump drags hardware along
   always_ff @(posedge clock_in) begin
      if (!rstn_in) begin
         stat_rev <= 16'h0000;
         hw_rev <= 16'h0000;
         fw_rev <= 16'h0000;
      end else begin
         if (cfg_wr) stat_rev <= stat_rev + 16'h0001;
         if (wr_go && avs_address_in == REG_FW_REV && merged[0]) begin
            fw_rev <= fw_rev + 16'h0001;
            hw_rev <= hw_rev + 16'h0001;
         end
      end
   end
endmodule

`default_nettype wire

// *** rtl/ifpc_pkg.sv ***
// Constants, register map and carrier types for the input conditioner
package ifpc_pkg;
   localparam int NUM_CH = 16; // Input channels
   localparam int NUM_GRP = 8; // Two channels per group
   localparam int CLK_HZ = 100000000; // Module clock rate
   localparam int TICK_MS_HZ = 1000; // Millisecond time base
   localparam int TICK_CYCLES = CLK_HZ / TICK_MS_HZ; // Cycles per tick

   // Stretch selections and their lengths in milliseconds
   localparam logic [1:0] STR_NONE = 2'h0;
   localparam logic [1:0] STR_500 = 2'h1;
   localparam logic [1:0] STR_1000 = 2'h2;
   localparam logic [1:0] STR_2000 = 2'h3;
   localparam logic [10:0] STR_500_MS = 11'd500;
   localparam logic [10:0] STR_1000_MS = 11'd1000;
   localparam logic [10:0] STR_2000_MS = 11'd2000;

   // Window code 0 is half a second, 1..100 whole seconds
   localparam logic [6:0] WIN_HALF = 7'h00;
   localparam logic [6:0] WIN_MAX = 7'h64;
   localparam logic [6:0] WIN_DEF = 7'h02;
   localparam logic [16:0] WIN_HALF_MS = 17'd500;
   localparam logic [9:0] MS_PER_S = 10'd1000;
   localparam logic [4:0] LIM_MIN = 5'h02;
   localparam logic [4:0] LIM_DEF = 5'h05;
   localparam logic [1:0] QUIET_WINDOWS = 2'h3; // Clean windows to clear an error

   // Sensor types, changeover kinds from CO_FIRST upward
   localparam logic [3:0] SNS_OFF = 4'h0;
   localparam logic [3:0] SNS_NAMUR = 4'h1;
   localparam logic [3:0] CO_FIRST = 4'h5;
   localparam logic [3:0] SNS_LAST = 4'h8;

   // Register byte offsets
   localparam logic [9:0] REG_CTRL = 10'h000;
   localparam logic [9:0] REG_GRP_DIAG = 10'h004;
   localparam logic [9:0] REG_FLUT_EN = 10'h008;
   localparam logic [9:0] REG_STRETCH = 10'h00c;
   localparam logic [9:0] REG_SENSOR = 10'h010;
   localparam logic [9:0] REG_IMAGE = 10'h020;
   localparam logic [9:0] REG_STATUS = 10'h024;
   localparam logic [9:0] REG_DIAG = 10'h028;
   localparam logic [9:0] REG_STAT_REV = 10'h034;
   localparam logic [9:0] REG_HW_REV = 10'h038;
   localparam logic [9:0] REG_FW_REV = 10'h03c;
   localparam logic [3:0] CHCFG_PAGE = 4'h1; // 0x040..0x07c, one word per channel
   localparam logic [9:0] REG_MAKER = 10'h080;
   localparam logic [9:0] REG_DEV_ID = 10'h084;
   localparam logic [9:0] REG_SERIAL = 10'h088;
   localparam logic [9:0] ID_BASE = 10'h100; // Date 4 words, tag 8, text 8
   localparam int ID_WORDS = 20;
   localparam logic [9:0] ID_END = 10'h150;

   // Reset values
   localparam logic [15:0] GRP_DIAG_RST = 16'hffff;
   localparam logic [3:0] SENSOR_RST = SNS_NAMUR;

   // Per-channel configuration carrier
   typedef struct packed {
      logic flut_en;
      logic [1:0] stretch;
      logic [6:0] win;
      logic [4:0] limit;
   } ifpc_cfg_type;
endpackage

// *** dv/ifpc_sensor_model.sv ***
// Field contact model driving the raw sensor levels
`timescale 1ns/10ps
`default_nettype none
module ifpc_sensor_model (
   input wire logic clock_in,
   output logic [15:0] level_out
);
   initial level_out = 16'h0000; // All contacts open at start
   // Close one contact for len cycles
   task automatic pulse(input int ch, input int len);
      @(posedge clock_in) level_out[ch] <= 1'b1;
      repeat (len) @(posedge clock_in);
      level_out[ch] <= 1'b0;
   endtask
   // Flip one contact n times, 21 cycles apart, like a worn switch
   task automatic chatter(input int ch, input int n);
      repeat (n) begin
         @(posedge clock_in) level_out[ch] <= ~level_out[ch];
         repeat (20) @(posedge clock_in);
      end
   endtask
   // Changeover pair: even is the open contact, odd the closed one
   task automatic flip_pair(input int g, input logic on);
      @(posedge clock_in) level_out[2*g] <= on;
      level_out[2*g+1] <= ~on;
   endtask
endmodule
`default_nettype wire

// *** dv/ifpc_assertions.sv ***
// Checker for bus handshake, value status and interrupt relations
`timescale 1ns/10ps
`default_nettype none
module ifpc_chk #(
   parameter int TICK_DIV = 100000 // Cycles per millisecond tick
) (
   input wire logic clock_in,
   input wire logic rstn_in,
   input wire logic [15:0] sensor_in,
   input wire logic [9:0] avs_address_in,
   input wire logic avs_read_in,
   input wire logic avs_write_in,
   input wire logic [31:0] avs_writedata_in,
   input wire logic [3:0] avs_byteenable_in,
   input wire logic [31:0] avs_readdata_out,
   input wire logic avs_waitrequest_out,
   input wire logic [15:0] image_out,
   input wire logic [15:0] valid_out,
   input wire logic [15:0] led_out,
   input wire logic diag_in_irq_out,
   input wire logic diag_out_irq_out
);
   // One clock domain: one clocking, one disable
   default clocking cb @(posedge clock_in);
   endclocking
   default disable iff (!rstn_in);
   wire logic req = avs_read_in | avs_write_in; // Any bus request
   // Request still waiting, and request answered
   sequence s_wait;
      req && avs_waitrequest_out;
   endsequence
   sequence s_done;
      req && !avs_waitrequest_out;
   endsequence
   // Some channel newly in error, or newly cleared, within three cycles
   sequence s_err_new;
      |(~valid_out & $past(valid_out, 3));
   endsequence
   sequence s_led_new;
      |(led_out & ~$past(led_out, 3));
   endsequence
   sequence s_ok_new;
      |(valid_out & ~$past(valid_out, 3));
   endsequence
   a_one_wait: assert property (s_wait |=> !avs_waitrequest_out)
      else $error("bus answer late");
   a_idle_quiet: assert property (!req |-> !avs_waitrequest_out)
      else $error("wait without request");
   a_ack_single: assert property (s_done ##1 req |-> avs_waitrequest_out)
      else $error("second answer without wait");
   a_rdata_holds: assert property ($changed(avs_readdata_out) |-> $past(avs_read_in))
      else $error("read data moved without read");
   a_led_in_err: assert property ((led_out & valid_out) == 16'h0000)
      else $error("indicator lit on valid channel");
   a_in_irq_err: assert property (diag_in_irq_out |-> ##[0:1] s_err_new)
      else $error("incoming interrupt without error");
   a_in_irq_led: assert property (diag_in_irq_out |-> ##[0:1] s_led_new)
      else $error("incoming interrupt without group diagnostics");
   a_out_irq_ok: assert property (diag_out_irq_out |-> ##[0:1] s_ok_new)
      else $error("outgoing interrupt without clearing");
   a_irq_pulse: assert property (diag_in_irq_out |=> !diag_in_irq_out)
      else $error("incoming interrupt too long");
endmodule
`default_nettype wire

// *** dv/test_ifpc_top.sv ***
// Self-checking bench for the input conditioner
`timescale 1ns/10ps
`default_nettype none
module test_ifpc_top;
   import ifpc_pkg::*;
   localparam int TD = 10; // Short tick: 1 ms is 10 cycles
   logic clock_in, rstn_in, rd_req, wr_req, wait_req, irq_in, irq_out;
   logic [9:0] addr; // Bus address
   logic [31:0] wdata, rdata, v, s; // Bus data and saved readings
   logic [3:0] be; // Byte lanes, all enabled
   logic [15:0] levels, image, valid, led; // Contacts and status
   int n_mismatch = 0, num_checks = 0, n_in = 0, n_out = 0; // Counters
   ifpc_top #(.TICK_DIV(TD)) i_dut (
      .clock_in(clock_in), .rstn_in(rstn_in), .sensor_in(levels),
      .avs_address_in(addr), .avs_read_in(rd_req), .avs_write_in(wr_req),
      .avs_writedata_in(wdata), .avs_byteenable_in(be), .avs_readdata_out(rdata),
      .avs_waitrequest_out(wait_req), .image_out(image), .valid_out(valid),
      .led_out(led), .diag_in_irq_out(irq_in), .diag_out_irq_out(irq_out)
   );
   ifpc_sensor_model i_snr (.clock_in(clock_in), .level_out(levels));
   // 100 MHz clock
   initial begin
      clock_in = 1'b0;
      forever #5 clock_in = ~clock_in;
   end
   // Interrupt pulses seen
   always @(posedge clock_in) begin
      if (irq_in === 1'b1) n_in++;
      if (irq_out === 1'b1) n_out++;
   end
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      num_checks++;
      if (seen !== exp) begin
         n_mismatch++;
         $display("CHECK FAILED at %0t: saw %h wanted %h", $time, seen, exp);
      end
   endtask
   // One transfer; request stands until waitrequest is seen low at a rising edge
   task automatic bus(input logic w, input logic [9:0] a, input logic [31:0] d,
                      output logic [31:0] q);
      logic busy;
      int n;
      n = 0;
      @(posedge clock_in);
      addr <= a;
      wdata <= d;
      rd_req <= ~w;
      wr_req <= w;
      do begin
         @(posedge clock_in);
         busy = wait_req;
         q = rdata;
         n++;
      end while (busy !== 1'b0 && n < 50);
      if (busy !== 1'b0) check(1'b1, 1'b0);
      rd_req <= 1'b0;
      wr_req <= 1'b0;
   endtask
   task automatic wr(input logic [9:0] a, input logic [31:0] d);
      logic [31:0] q;
      bus(1'b1, a, d, q);
   endtask
   task automatic rd_chk(input logic [9:0] a, input logic [31:0] e);
      logic [31:0] q;
      bus(1'b0, a, 32'h0, q);
      check(q, e);
   endtask
   // Wait n edges, then sample at mid-cycle
   task automatic cyc(input int n);
      repeat (n) @(posedge clock_in);
      @(negedge clock_in);
   endtask
   task automatic give_verdict();
      $display("checks %0d mismatches %0d", num_checks, n_mismatch);
      if (n_mismatch == 0 && num_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask
   // Reset state, read-only and unmapped places, revisions, identity text
   task automatic t_regs();
      check(valid, 16'hffff);
      check(image | led, 16'h0);
      rd_chk(REG_CTRL, 32'h0);
      rd_chk(REG_GRP_DIAG, 32'h0000ffff);
      rd_chk(REG_FLUT_EN, 32'h0);
      rd_chk(10'h3fc, 32'h0);
      rd_chk(ID_END, 32'h0);
      wr(REG_IMAGE, 32'hffffffff);
      rd_chk(REG_IMAGE, 32'h0);
      bus(1'b0, REG_STAT_REV, 32'h0, s);
      wr(REG_CTRL, 32'h1);
      wr(REG_CTRL, 32'h1);
      rd_chk(REG_STAT_REV, s + 32'h2);
      bus(1'b0, REG_HW_REV, 32'h0, s);
      bus(1'b0, REG_FW_REV, 32'h0, v);
      wr(REG_HW_REV, 32'h5);
      wr(REG_FW_REV, 32'h1);
      rd_chk(REG_FW_REV, v + 32'h1);
      rd_chk(REG_HW_REV, s + 32'h1);
      wr(10'h048, 32'h00007f00);
      rd_chk(10'h048, 32'h00006402);
      wr(ID_BASE, 32'h30312e30); // Date text "01.0"
      rd_chk(ID_BASE, 32'h30312e30);
      wr(10'h14c, 32'h74787421);
      rd_chk(10'h14c, 32'h74787421);
      $display("t_regs done");
   endtask
   // Every stretch code on a short pulse, then a pulse longer than the hold
   task automatic t_stretch();
      int ms[4] = '{0, STR_500_MS, STR_1000_MS, STR_2000_MS};
      for (int c = 0; c < 4; c++) begin
         wr(REG_STRETCH, 32'(c) << 2);
         i_snr.pulse(1, 20);
         if (c > 0) begin
            cyc(ms[c] * TD - 130);
            check(image[1], 1'b1);
         end
         cyc(220);
         check(image[1], 1'b0);
      end
      wr(REG_STRETCH, 32'h4);
      i_snr.pulse(1, 6000);
      cyc(8);
      check(image[1], 1'b0);
      $display("t_stretch done");
   endtask
   // Flutter on ch2 (gated) and ch4 (group diag off), ch3 stretched, ch0 off
   task automatic t_flutter();
      int i0;
      wr(REG_FLUT_EN, 32'h1c);
      wr(10'h048, 32'h2);
      wr(10'h04c, 32'h2);
      wr(10'h050, 32'h2);
      wr(REG_GRP_DIAG, 32'hffef);
      wr(REG_STRETCH, 32'h40);
      repeat (3) i_snr.pulse(3, 20);
      i_snr.chatter(2, 2);
      i_snr.chatter(0, 5);
      cyc(6000);
      check(valid, 16'hffff);
      i0 = n_in;
      i_snr.chatter(2, 3);
      i_snr.chatter(4, 3);
      cyc(1);
      check(valid, 16'hffeb);
      check(led, 16'h0004);
      check(image[2], 1'b1);
      check(n_in - i0, 1);
      rd_chk(REG_DIAG, 32'h4);
      rd_chk(REG_STATUS, 32'h0000ffeb);
      cyc(13600);
      check(valid[2], 1'b0);
      cyc(1500);
      check(valid, 16'hffff);
      check(n_out, 1);
      rd_chk(REG_DIAG, 32'h0);
      $display("t_flutter done");
   endtask
   // Group sensor types: changeover pair and a switched-off group
   task automatic t_sensor();
      wr(REG_SENSOR, 32'h11105111);
      wr(REG_SENSOR, 32'h1110f111);
      rd_chk(REG_SENSOR, 32'h11105111);
      i_snr.flip_pair(3, 1'b1);
      i_snr.flip_pair(4, 1'b1);
      cyc(8);
      check(image[9:6], 4'h3);
      i_snr.flip_pair(3, 1'b0);
      i_snr.flip_pair(4, 1'b0);
      cyc(8);
      check(image[9:6], 4'h0);
      $display("t_sensor done");
   endtask
   // Main sequence
   initial begin
      rstn_in = 1'b0;
      rd_req = 1'b0;
      wr_req = 1'b0;
      addr = 10'h000;
      wdata = 32'h0;
      be = 4'hf;
      repeat (8) @(posedge clock_in);
      rstn_in <= 1'b1;
      cyc(2);
      t_regs();
      t_stretch();
      t_flutter();
      t_sensor();
      give_verdict();
   end
   // Watchdog, well past the expected run length
   initial begin
      repeat (90000) @(posedge clock_in);
      n_mismatch++;
      give_verdict();
   end
endmodule
bind ifpc_top ifpc_chk #(.TICK_DIV(TICK_DIV)) i_chk (
   .clock_in(clock_in), .rstn_in(rstn_in), .sensor_in(sensor_in),
   .avs_address_in(avs_address_in), .avs_read_in(avs_read_in),
   .avs_write_in(avs_write_in), .avs_writedata_in(avs_writedata_in),
   .avs_byteenable_in(avs_byteenable_in), .avs_readdata_out(avs_readdata_out),
   .avs_waitrequest_out(avs_waitrequest_out), .image_out(image_out),
   .valid_out(valid_out), .led_out(led_out), .diag_in_irq_out(diag_in_irq_out),
   .diag_out_irq_out(diag_out_irq_out)
);
`default_nettype wire
